// file: pkg/nvmac_params.svh
`ifndef NVMAC_PARAMS_SVH
`define NVMAC_PARAMS_SVH

// =====================================================
// Register offsets on the byte-wide register port
`define NVMAC_OFS_CTRL 8'h00
`define NVMAC_OFS_UNLOCK 8'h01
`define NVMAC_OFS_ADDR 8'h02
`define NVMAC_OFS_DATA 8'h03

// =====================================================
// Control register field positions
`define NVMAC_BIT_PGM 7
`define NVMAC_BIT_CFG 6
`define NVMAC_BIT_FREE 4
`define NVMAC_BIT_WERR 3
`define NVMAC_BIT_WRITE_ENABLE 2
`define NVMAC_BIT_WR 1
`define NVMAC_BIT_RD 0

// =====================================================
// Reset values and unlock key
`define NVMAC_CTRL_RESET 8'h00
`define NVMAC_BYTE_RESET 8'h00
`define NVMAC_KEY_FIRST 8'h55
`define NVMAC_KEY_SECOND 8'hAA

// =====================================================
// Timing
`define NVMAC_CLK_MHZ 200
`define NVMAC_PWRUP_TIME_MS 72
`define NVMAC_PWRUP_CYCLES (`NVMAC_PWRUP_TIME_MS * `NVMAC_CLK_MHZ * 1000)
`define NVMAC_WRITE_TIME_US 4
`define NVMAC_WRITE_CYCLES (`NVMAC_WRITE_TIME_US * `NVMAC_CLK_MHZ)

`endif

// file: pkg/nvmac_pkg.sv
package nvmac_pkg;

	typedef enum {
		UNL_IDLE,
		UNL_HALF,
		UNL_ARMED
	} nvmac_unlock_type;

	typedef enum {
		WRS_IDLE,
		WRS_BUSY
	} nvmac_wrstate_type;

	typedef enum logic [1:0] {
		TGT_EEPROM,
		TGT_FLASH,
		TGT_CONFIG
	} nvmac_target_type;

endpackage

// file: hdl/nvmac_byte_mem.sv
`timescale 1ns/1ps

module nvmac_byte_mem
	import nvmac_pkg::*;
(
	input wire logic clk,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic we,
	input wire logic re,
	output logic [7:0] rdata
);

	logic [7:0] cells [0:255];

	// =====================================================
	// Single port, registered read data
	always_ff @(posedge clk)
	begin
		if (we)
		begin
			cells[addr] <= wdata;
		end
		if (re)
		begin
			rdata <= cells[addr];
		end
	end

endmodule // nvmac_byte_mem

// file: hdl/nvmac_top.sv
`timescale 1ns/1ps
`include "nvmac_params.svh"


module nvmac_top
	import nvmac_pkg::*;
#(
	parameter int PWRUP_CYCLES = `NVMAC_PWRUP_CYCLES
)
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [7:0] busAddr,
	input wire logic [7:0] busWdata,
	input wire logic busWrite,
	input wire logic busRead,
	output logic [7:0] busRdata,
	input wire logic extResetEvent,
	input wire logic watchdogEvent,
	input wire logic codeProtect,
	input wire logic [7:0] extPgmAddr,
	input wire logic [7:0] extPgmWdata,
	input wire logic extPgmWrite,
	input wire logic extPgmRead,
	output logic [7:0] extPgmRdata,
	output logic extPgmBlocked,
	output logic flashOpStart,
	output logic flashOpErase,
	output nvmac_target_type opTarget,
	output logic writeBusy
);

	localparam logic [15:0] WRITE_CYCLES = 16'(`NVMAC_WRITE_CYCLES);
	localparam int WR_MAX = 1000;

	logic pgm_q, cfg_q, free_q, write_error_flag_q, write_enable_q, wr_q, rd_q;
	logic rdIssued_q, extRdPend_q, puDone_q;
	logic [7:0] addr_q, data_q;
	logic [23:0] puCnt_q;
	logic [15:0] wrCnt_q;
	nvmac_unlock_type unlock_q;
	nvmac_wrstate_type wrState_q;
	logic ctrlWrite, warm, wrDone, startOk, rdIssue, extGrant;
	logic newPgm, newCfg;
	nvmac_target_type newTarget;
	logic [7:0] memAddr, memWdata, memRdata;
	logic memWe, memRe;

	// =====================================================
	// Decode
	assign ctrlWrite = busWrite && (busAddr == `NVMAC_OFS_CTRL);
	assign warm = extResetEvent || watchdogEvent;
	assign newPgm = busWdata[`NVMAC_BIT_PGM];
	assign newCfg = busWdata[`NVMAC_BIT_CFG];
	assign wrDone = (wrState_q == WRS_BUSY) && (wrCnt_q == 16'h0001);

	always_comb
	begin
		if (newCfg)
		begin
			newTarget = TGT_CONFIG;
		end
		else if (newPgm)
		begin
			newTarget = TGT_FLASH;
		end
		else
		begin
			newTarget = TGT_EEPROM;
		end
	end

	// Start needs key, prior enable and, for EEPROM, elapsed power-up
	assign startOk = ctrlWrite && busWdata[`NVMAC_BIT_WR] && !wr_q
		&& (unlock_q == UNL_ARMED) && write_enable_q
		&& !(newTarget == TGT_EEPROM && !puDone_q);

	// =====================================================
	// Power-up timer
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			puCnt_q <= 24'h000000;
			puDone_q <= 1'b0;
		end
		else if (!puDone_q)
		begin
			puCnt_q <= puCnt_q + 24'h000001;
			puDone_q <= (puCnt_q == 24'(PWRUP_CYCLES - 1));
		end
	end

	// =====================================================
	// Unlock sequence
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			unlock_q <= UNL_IDLE;
		end
		else if (warm || ctrlWrite)
		begin
			unlock_q <= UNL_IDLE;
		end
		else if (busWrite)
		begin
			if (busAddr == `NVMAC_OFS_UNLOCK
				&& busWdata == `NVMAC_KEY_FIRST)
			begin
				unlock_q <= UNL_HALF;
			end
			else if (busAddr == `NVMAC_OFS_UNLOCK
				&& busWdata == `NVMAC_KEY_SECOND
				&& unlock_q == UNL_HALF)
			begin
				unlock_q <= UNL_ARMED;
			end
			else if (unlock_q != UNL_ARMED)
			begin
				unlock_q <= UNL_IDLE;
			end
		end
	end

	// =====================================================
	// Control register
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pgm_q <= 1'b0;
			cfg_q <= 1'b0;
			free_q <= 1'b0;
			write_error_flag_q <= 1'b0;
			write_enable_q <= 1'b0;
		end
		else if (warm)
		begin
			write_enable_q <= 1'b0;
			if (wrState_q == WRS_BUSY)
			begin
				write_error_flag_q <= 1'b1;
			end
		end
		else
		begin
			if (ctrlWrite)
			begin
				pgm_q <= newPgm;
				cfg_q <= newCfg;
				write_error_flag_q <= busWdata[`NVMAC_BIT_WERR];
				write_enable_q <= busWdata[`NVMAC_BIT_WRITE_ENABLE];
				free_q <= busWdata[`NVMAC_BIT_FREE];
			end
			if (startOk && busWdata[`NVMAC_BIT_FREE]
				&& newTarget != TGT_EEPROM)
			begin
				free_q <= 1'b0;
			end
		end
	end

	// =====================================================
	// Self-timed write sequencer
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wrState_q <= WRS_IDLE;
			wr_q <= 1'b0;
			wrCnt_q <= 16'h0000;
			opTarget <= TGT_EEPROM;
			flashOpErase <= 1'b0;
			flashOpStart <= 1'b0;
			writeBusy <= 1'b0;
		end
		else
		begin
			flashOpStart <= 1'b0;
			case (wrState_q)
				WRS_IDLE:
				begin
					if (startOk && !warm)
					begin
						wrState_q <= WRS_BUSY;
						wr_q <= 1'b1;
						writeBusy <= 1'b1;
						wrCnt_q <= WRITE_CYCLES;
						opTarget <= newTarget;
						flashOpErase <= busWdata[`NVMAC_BIT_FREE]
							&& newTarget != TGT_EEPROM;
						flashOpStart <= (newTarget != TGT_EEPROM);
					end
				end
				WRS_BUSY:
				begin
					if (warm || wrDone)
					begin
						wrState_q <= WRS_IDLE;
						wr_q <= 1'b0;
						writeBusy <= 1'b0;
						flashOpErase <= 1'b0;
						wrCnt_q <= 16'h0000;
					end
					else
					begin
						wrCnt_q <= wrCnt_q - 16'h0001;
					end
				end
				default:
				begin
					wrState_q <= WRS_IDLE;
					wr_q <= 1'b0;
					writeBusy <= 1'b0;
				end
			endcase
		end
	end

	// =====================================================
	// Read sequencer and address/data registers
	assign rdIssue = rd_q && !rdIssued_q && !(wrDone && !warm);

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rd_q <= 1'b0;
			rdIssued_q <= 1'b0;
		end
		else if (warm)
		begin
			rd_q <= 1'b0;
			rdIssued_q <= 1'b0;
		end
		else if (rdIssued_q)
		begin
			rd_q <= 1'b0;
			rdIssued_q <= 1'b0;
		end
		else if (rdIssue)
		begin
			rdIssued_q <= 1'b1;
		end
		else if (ctrlWrite && busWdata[`NVMAC_BIT_RD]
			&& !newPgm && !newCfg)
		begin
			rd_q <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			addr_q <= `NVMAC_BYTE_RESET;
			data_q <= `NVMAC_BYTE_RESET;
		end
		else if (warm)
		begin
			addr_q <= `NVMAC_BYTE_RESET;
			data_q <= `NVMAC_BYTE_RESET;
		end
		else
		begin
			if (busWrite && busAddr == `NVMAC_OFS_ADDR)
			begin
				addr_q <= busWdata;
			end
			if (rdIssued_q)
			begin
				data_q <= memRdata;
			end
			else if (busWrite && busAddr == `NVMAC_OFS_DATA)
			begin
				data_q <= busWdata;
			end
		end
	end

	// =====================================================
	// Array port arbitration: processor first, never code-protected
	assign extGrant = !codeProtect && (extPgmWrite || extPgmRead)
		&& !wrDone && !rdIssue;

	always_comb
	begin
		memAddr = addr_q;
		memWdata = data_q;
		memWe = 1'b0;
		memRe = 1'b0;
		if (wrDone && !warm && opTarget == TGT_EEPROM)
		begin
			memWe = 1'b1;
		end
		else if (rdIssue)
		begin
			memRe = 1'b1;
		end
		else if (extGrant)
		begin
			memAddr = extPgmAddr;
			memWdata = extPgmWdata;
			memWe = extPgmWrite;
			memRe = extPgmRead && !extPgmWrite;
		end
	end

	nvmac_byte_mem u_mem
	(
		.clk(clk),
		.addr(memAddr),
		.wdata(memWdata),
		.we(memWe),
		.re(memRe),
		.rdata(memRdata)
	);

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			extRdPend_q <= 1'b0;
			extPgmRdata <= 8'h00;
			extPgmBlocked <= 1'b0;
		end
		else
		begin
			extRdPend_q <= extGrant && extPgmRead && !extPgmWrite;
			extPgmBlocked <= codeProtect;
			if (extRdPend_q)
			begin
				extPgmRdata <= memRdata;
			end
		end
	end

	// =====================================================
	// Register read port
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			busRdata <= 8'h00;
		end
		else if (busRead)
		begin
			case (busAddr)
				`NVMAC_OFS_CTRL:
				begin
					busRdata <= {pgm_q, cfg_q, 1'b0, free_q,
						write_error_flag_q, write_enable_q, wr_q, rd_q};
				end
				`NVMAC_OFS_ADDR:
				begin
					busRdata <= addr_q;
				end
				`NVMAC_OFS_DATA:
				begin
					busRdata <= data_q;
				end
				default:
				begin
					busRdata <= 8'h00;
				end
			endcase
		end
	end

	// =====================================================
	// Checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	start_needs_key_a: assert property (
		$rose(wr_q) |-> $past(write_enable_q) && $past(unlock_q) == UNL_ARMED)
		else $error("write started without key or enable");

	pwrup_block_a: assert property (
		$rose(wr_q) && opTarget == TGT_EEPROM |-> $past(puDone_q))
		else $error("EEPROM write during power-up timer");

	wr_self_clear_a: assert property (
		$rose(wr_q) |-> ##[1:WR_MAX] !wr_q)
		else $error("write bit not cleared by hardware");

	rd_self_clear_a: assert property (
		$rose(rd_q) |-> !pgm_q ##2 !rd_q)
		else $error("read bit wrong or not cleared");

	abort_flag_a: assert property (
		wr_q && warm |=> write_error_flag_q && !wr_q && addr_q == 8'h00)
		else $error("aborted write did not flag error");

	erase_clear_a: assert property (
		$rose(wr_q) && flashOpErase |-> !free_q && flashOpStart)
		else $error("erase enable not cleared at start");

	target_sel_a: assert property (
		$rose(wr_q) |-> (opTarget == TGT_CONFIG) == cfg_q
		&& (cfg_q || ((opTarget == TGT_FLASH) == pgm_q)))
		else $error("operation target wrong");

	unlock_zero_a: assert property (
		busRead && busAddr == `NVMAC_OFS_UNLOCK |=> busRdata == 8'h00)
		else $error("unlock port read not zero");

	bit5_zero_a: assert property (
		busRead && busAddr == `NVMAC_OFS_CTRL |=> busRdata[5] == 1'b0)
		else $error("control bit 5 not zero");

	protect_a: assert property (
		codeProtect |-> !extGrant ##1 extPgmBlocked)
		else $error("external access while protected");

	done_c: cover property (wr_q && wrDone && opTarget == TGT_EEPROM);
	abort_c: cover property (wr_q && warm);
	read_c: cover property (rdIssued_q);
	ext_c: cover property (extRdPend_q);

endmodule // nvmac_top

// file: testbench/tb_top.sv
`timescale 1ns/1ps
`include "nvmac_params.svh"

// ==========================================
// Compare helper
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
	fail_count++; $display("unexpected %s exp %h got %h", n, e, g); end end

module tb_top
	import nvmac_pkg::*;
;
	localparam logic [7:0] CT = `NVMAC_OFS_CTRL;
	localparam logic [7:0] UK = `NVMAC_OFS_UNLOCK;
	localparam logic [7:0] AD = `NVMAC_OFS_ADDR;
	localparam logic [7:0] DT = `NVMAC_OFS_DATA;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] busAddr = 8'h00;
	logic [7:0] busWdata = 8'h00;
	logic busWrite = 1'b0;
	logic busRead = 1'b0;
	logic [7:0] busRdata;
	logic extResetEvent = 1'b0;
	logic watchdogEvent = 1'b0;
	logic codeProtect = 1'b0;
	logic [7:0] extPgmAddr = 8'h00;
	logic [7:0] extPgmWdata = 8'h00;
	logic extPgmWrite = 1'b0;
	logic extPgmRead = 1'b0;
	logic [7:0] extPgmRdata;
	logic extPgmBlocked;
	logic flashOpStart;
	logic flashOpErase;
	nvmac_target_type opTarget;
	logic writeBusy;
	int fail_count = 0;
	int check_count = 0;
	logic [7:0] v;
	int n;

	nvmac_top #(.PWRUP_CYCLES(20)) nvmac_top_i (.clk(clk),
		.reset_n(reset_n), .busAddr(busAddr), .busWdata(busWdata),
		.busWrite(busWrite), .busRead(busRead), .busRdata(busRdata),
		.extResetEvent(extResetEvent), .watchdogEvent(watchdogEvent),
		.codeProtect(codeProtect), .extPgmAddr(extPgmAddr),
		.extPgmWdata(extPgmWdata), .extPgmWrite(extPgmWrite),
		.extPgmRead(extPgmRead), .extPgmRdata(extPgmRdata),
		.extPgmBlocked(extPgmBlocked), .flashOpStart(flashOpStart),
		.flashOpErase(flashOpErase), .opTarget(opTarget),
		.writeBusy(writeBusy));

	always #2.5 clk = ~clk;

	// ==========================================
	// Bus and port tasks
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		busWrite <= 1'b1;
		busAddr <= a;
		busWdata <= d;
		@(posedge clk);
		busWrite <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		busRead <= 1'b1;
		busAddr <= a;
		@(posedge clk);
		busRead <= 1'b0;
		#1;
		d = busRdata;
	endtask

	task automatic unlock();
		wr(UK, `NVMAC_KEY_FIRST);
		wr(UK, `NVMAC_KEY_SECOND);
	endtask

	task automatic start(input logic [7:0] c);
		unlock();
		wr(CT, c);
		#1;
	endtask

	task automatic wait_idle();
		n = 1;
		while (writeBusy !== 1'b0 && n < 1000)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n >= 1000)
		begin
			fail_count++;
			summarize();
		end
	endtask

	task automatic ext(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		@(posedge clk);
		extPgmWrite <= w;
		extPgmRead <= !w;
		extPgmAddr <= a;
		extPgmWdata <= d;
		@(posedge clk);
		extPgmWrite <= 1'b0;
		extPgmRead <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
	endtask

	// ==========================================
	// Scenarios
	task automatic t_reset();
		rd(CT, v); `CHK("ctrl", 8'h00, v)
		rd(UK, v); `CHK("unlock", 8'h00, v)
		rd(8'h04, v); `CHK("unmapped", 8'h00, v)
	endtask

	task automatic t_pwrup();
		wr(CT, 8'h04);
		start(8'h06);
		`CHK("busy", 1'b0, writeBusy)
		rd(CT, v); `CHK("ctrl", 8'h04, v)
		repeat (30) @(posedge clk);
	endtask

	task automatic t_refused();
		wr(CT, 8'h06);
		@(posedge clk);
		#1;
		`CHK("busy", 1'b0, writeBusy)
		wr(CT, 8'h00);
		start(8'h02);
		`CHK("busy", 1'b0, writeBusy)
		wr(CT, 8'h24);
		rd(CT, v); `CHK("ctrl", 8'h04, v)
	endtask

	task automatic t_write();
		wr(AD, 8'h10);
		wr(DT, 8'h5A);
		start(8'h06);
		`CHK("busy", 1'b1, writeBusy)
		`CHK("target", TGT_EEPROM, opTarget)
		wait_idle();
		`CHK("time", 1'b1, n >= 799 && n <= 801)
		wr(DT, 8'h00);
		wr(CT, 8'h05);
		repeat (3) @(posedge clk);
		rd(DT, v); `CHK("data", 8'h5A, v)
		rd(CT, v); `CHK("ctrl", 8'h04, v)
	endtask

	task automatic t_flash();
		wr(CT, 8'h94);
		start(8'h96);
		`CHK("start", 1'b1, flashOpStart)
		`CHK("erase", 1'b1, flashOpErase)
		`CHK("target", TGT_FLASH, opTarget)
		wait_idle();
		rd(CT, v); `CHK("ctrl", 8'h84, v)
		wr(CT, 8'hC4);
		start(8'hC6);
		`CHK("target", TGT_CONFIG, opTarget)
		wait_idle();
		wr(CT, 8'h81);
		rd(CT, v); `CHK("ctrl", 8'h80, v)
	endtask

	task automatic t_protect();
		wr(CT, 8'h00);
		ext(1'b0, 8'h10, 8'h00);
		`CHK("extrd", 8'h5A, extPgmRdata)
		ext(1'b1, 8'h20, 8'h3C);
		ext(1'b0, 8'h20, 8'h00);
		`CHK("extrd", 8'h3C, extPgmRdata)
		codeProtect <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		`CHK("blocked", 1'b1, extPgmBlocked)
		ext(1'b1, 8'h10, 8'hA5);
		ext(1'b0, 8'h10, 8'h00);
		`CHK("extrd", 8'h3C, extPgmRdata)
		wr(AD, 8'h10);
		wr(CT, 8'h01);
		repeat (3) @(posedge clk);
		rd(DT, v); `CHK("data", 8'h5A, v)
		@(posedge clk);
		codeProtect <= 1'b0;
	endtask

	// Read bytes 0x10 and 0x20 and write each back, then verify it survived
	task automatic t_refresh();
		logic [7:0] a;
		logic [7:0] e;
		for (int i = 0; i < 2; i++)
		begin
			a = (i == 0) ? 8'h10 : 8'h20;
			e = (i == 0) ? 8'h5A : 8'h3C;
			wr(CT, 8'h04);
			wr(AD, a);
			wr(CT, 8'h05);
			repeat (3) @(posedge clk);
			start(8'h06);
			`CHK("rbusy", 1'b1, writeBusy)
			wait_idle();
			wr(DT, 8'h00);
			wr(CT, 8'h05);
			repeat (3) @(posedge clk);
			rd(DT, v); `CHK("refresh", e, v)
		end
	endtask

	task automatic t_warm();
		wr(CT, 8'h04);
		start(8'h06);
		repeat (5) @(posedge clk);
		watchdogEvent <= 1'b1;
		@(posedge clk);
		watchdogEvent <= 1'b0;
		@(posedge clk);
		#1;
		`CHK("busy", 1'b0, writeBusy)
		rd(CT, v); `CHK("ctrl", 8'h08, v)
		rd(AD, v); `CHK("addr", 8'h00, v)
		wr(CT, 8'h04);
		start(8'h06);
		@(posedge clk);
		extResetEvent <= 1'b1;
		@(posedge clk);
		extResetEvent <= 1'b0;
		rd(CT, v); `CHK("ctrl", 8'h08, v)
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial
	begin
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		t_reset();
		t_pwrup();
		t_refused();
		t_write();
		t_flash();
		t_protect();
		t_refresh();
		t_warm();
		summarize();
	end
endmodule // tb_top
